// ==== verilog/tws_pkg.sv ====
/*
  Shared constants, types and state encodings for the two-wire register
  slave and its bus master. Assumes both ends compile against this package.
*/
package tws_pkg;
  // Quarter of a serial bit as the master times it
  localparam int TWS_QUARTER_NS = 320;
  localparam int TWS_SYS_CLK_NS = 10;
  localparam int TWS_QUARTER_CYC = (TWS_QUARTER_NS + TWS_SYS_CLK_NS - 1) / TWS_SYS_CLK_NS;
  // Register map
  localparam logic [7:0] TWS_BYTE_WISE_LOW_HALF = 8'hf0;
  localparam logic [7:0] TWS_PTR_RST = 8'h00;
  localparam logic [3:0] TWS_BITS_PER_BYTE = 4'h8;
  typedef logic [7:0] tws_addr_t;
  typedef logic [15:0] tws_word_t;
  typedef enum logic [2:0] {TWS_D_IDLE, TWS_D_ID, TWS_D_REG, TWS_D_WR, TWS_D_ACK, TWS_D_RD, TWS_D_RACK} tws_dev_st_e;
  typedef enum logic [1:0] {TWS_H_IDLE, TWS_H_START, TWS_H_BYTE, TWS_H_STOP} tws_host_st_e;
  // Seven-bit identifier for each strap pair
  function automatic logic [6:0] tws_id7(input logic [1:0] sel);
    case (sel)
      2'h0: tws_id7 = 7'h48;
      2'h1: tws_id7 = 7'h4c;
      2'h2: tws_id7 = 7'h58;
      default: tws_id7 = 7'h5c;
    endcase
  endfunction : tws_id7
endpackage : tws_pkg

// ==== verilog/tws_if.sv ====
/*
  Two-wire bus between master and slave, with the pull-ups resolved here.
  Assumes every driver only ever pulls low.
*/
`timescale 1ns/1ps
interface tws_if;
  logic scl_o_host;
  logic scl_oe_host;
  logic sda_o_host;
  logic sda_oe_host;
  logic sda_o_dev;
  logic sda_oe_dev;
  logic scl;
  logic sda;
  // Wired-and with pull-up: an enabled driver wins
  assign scl = ~(scl_oe_host & ~scl_o_host);
  assign sda = ~((sda_oe_host & ~sda_o_host) | (sda_oe_dev & ~sda_o_dev));
  modport host (output scl_o_host, output scl_oe_host, output sda_o_host, output sda_oe_host, input scl, input sda);
  modport dev (output sda_o_dev, output sda_oe_dev, input scl, input sda);
endinterface : tws_if

// ==== verilog/tws_slave.sv ====
/*
  Two-wire slave giving a bus master access to 255 of its 256 sixteen-bit registers, 0xF0 being the byte-wise port.
  Runs on the sensor's own clock (clk_link); the serial lines and straps
  are foreign to it and are synchronised. Assumes the serial clock is slow
  against clk_link: each bus quarter lasts at least four clk_link cycles.
*/
`timescale 1ns/1ps
module tws_slave (
  input wire logic clk_link,
  input wire logic resetn,
  tws_if.dev bus,
  input wire logic id_select_pin_low,
  input wire logic id_select_pin_high,
  input wire tws_pkg::tws_addr_t core_rd_addr,
  output tws_pkg::tws_word_t core_rd_data,
  output logic reg_wr_stb,
  output tws_pkg::tws_addr_t reg_wr_addr,
  output tws_pkg::tws_word_t reg_wr_data
);
  import tws_pkg::*;

  typedef struct packed {
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic scl_p;
    logic sda_p;
    tws_dev_st_e st;
    tws_dev_st_e nxt;
    logic [3:0] cnt;
    logic [7:0] sh;
    tws_addr_t ptr;
    tws_addr_t hi_addr;
    tws_addr_t last_rd;
    logic [7:0] hi;
    logic phase;
    logic ack;
    logic oe;
    logic wstb;
    tws_addr_t waddr;
    tws_word_t wdata;
    tws_word_t core;
  } tws_dev_s;

  tws_dev_s q;
  tws_dev_s d;
  tws_word_t mem_q [256];
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic load;
  logic [6:0] my_id7;
  logic [7:0] rbyte;

  // Edge and condition detection on the second synchroniser stage only
  assign rise = q.sy2[0] & ~q.scl_p;
  assign fall = ~q.sy2[0] & q.scl_p;
  assign start = q.sy2[0] & q.scl_p & q.sda_p & ~q.sy2[1];
  assign stop = q.sy2[0] & q.scl_p & ~q.sda_p & q.sy2[1];
  assign my_id7 = tws_id7(q.sy2[3:2]);

  // Byte to send next; 0xF0 yields the low half of the last upper byte read
  always_comb begin
    if (q.ptr == TWS_BYTE_WISE_LOW_HALF && !q.phase) begin
      rbyte = mem_q[q.last_rd][7:0];
    end else if (!q.phase) begin
      rbyte = mem_q[q.ptr][15:8];
    end else begin
      rbyte = mem_q[q.ptr][7:0];
    end
  end

  // Next-state logic of the serial engine
  always_comb begin
    d = q;
    load = 1'b0;
    d.wstb = 1'b0;
    d.sy1 = {id_select_pin_high, id_select_pin_low, bus.sda, bus.scl};
    d.sy2 = q.sy1;
    d.scl_p = q.sy2[0];
    d.sda_p = q.sy2[1];
    d.core = mem_q[core_rd_addr];
    if (start) begin
      // A start, repeated or not, always restarts framing
      d.st = TWS_D_ID;
      d.cnt = 4'h0;
      d.oe = 1'b0;
      d.phase = 1'b0;
    end else if (stop) begin
      d.st = TWS_D_IDLE;
      d.oe = 1'b0;
    end else begin
      unique case (q.st)
        TWS_D_IDLE: begin
          d.oe = 1'b0;
        end
        TWS_D_ID, TWS_D_REG, TWS_D_WR: begin
          if (rise) begin
            // Sample while clock is high, MSB first
            d.sh = {q.sh[6:0], q.sy2[1]};
            d.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == TWS_BITS_PER_BYTE) begin
            d.cnt = 4'h0;
            d.st = TWS_D_ACK;
            d.oe = 1'b1;
            d.nxt = TWS_D_WR;
            if (q.st == TWS_D_ID) begin
              if (q.sh[7:1] == my_id7) begin
                // Direction bit picks read or write
                d.nxt = q.sh[0] ? TWS_D_RD : TWS_D_REG;
              end else begin
                d.oe = 1'b0;
                d.st = TWS_D_IDLE;
              end
            end else if (q.st == TWS_D_REG) begin
              d.ptr = q.sh;
              d.phase = 1'b0;
            end else if (q.ptr == TWS_BYTE_WISE_LOW_HALF && !q.phase) begin
              // Low half completes the word whose upper half was held
              d.wstb = 1'b1;
              d.waddr = q.hi_addr;
              d.wdata = {q.hi, q.sh};
            end else if (!q.phase) begin
              // Upper byte only held; the register is untouched yet
              d.hi = q.sh;
              d.hi_addr = q.ptr;
              d.phase = 1'b1;
            end else begin
              d.wstb = 1'b1;
              d.waddr = q.ptr;
              d.wdata = {q.hi, q.sh};
              d.ptr = q.ptr + 8'h01;
              d.phase = 1'b0;
            end
          end
        end
        TWS_D_ACK: begin
          // Hold the acknowledge through the whole ninth pulse
          if (fall) begin
            d.oe = 1'b0;
            d.st = q.nxt;
            load = (q.nxt == TWS_D_RD);
          end
        end
        TWS_D_RD: begin
          if (rise) begin
            d.cnt = q.cnt + 4'h1;
          end else if (fall) begin
            if (q.cnt == TWS_BITS_PER_BYTE) begin
              d.oe = 1'b0;
              d.st = TWS_D_RACK;
            end else begin
              // Next bit goes out only after the clock fell
              d.sh = {q.sh[6:0], 1'b0};
              d.oe = ~q.sh[6];
            end
          end
        end
        TWS_D_RACK: begin
          if (rise) begin
            d.ack = ~q.sy2[1];
          end else if (fall) begin
            if (q.ack) begin
              load = 1'b1;
            end else begin
              d.st = TWS_D_IDLE;
              d.oe = 1'b0;
            end
          end
        end
        // Code 7 is unused; fall back to idle with data released
        default: begin
          d.st = TWS_D_IDLE;
          d.oe = 1'b0;
        end
      endcase
    end
    // Put the first bit of a read byte on the line; step the pointer once the pointed register's low byte goes out
    if (load) begin
      d.sh = rbyte;
      d.oe = ~rbyte[7];
      d.cnt = 4'h0;
      d.st = TWS_D_RD;
      if (q.ptr == TWS_BYTE_WISE_LOW_HALF && !q.phase) begin
        d.phase = 1'b0;
      end else if (!q.phase) begin
        d.last_rd = q.ptr;
        d.phase = 1'b1;
      end else begin
        d.ptr = q.ptr + 8'h01;
        d.phase = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk_link) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Register array has no reset; a store lands one cycle after the commit
  always_ff @(posedge clk_link) begin
    if (q.wstb) begin
      mem_q[q.waddr] <= q.wdata;
    end
  end

  // Slave only ever pulls data low and never touches the clock
  assign bus.sda_o_dev = 1'b0;
  assign bus.sda_oe_dev = q.oe;
  assign core_rd_data = q.core;
  assign reg_wr_stb = q.wstb;
  assign reg_wr_addr = q.waddr;
  assign reg_wr_data = q.wdata;
endmodule : tws_slave

// ==== verilog/tws_master.sv ====
/*
  Two-wire bus master that runs one register write or read per command.
  Assumes the slave samples the lines on a clock at least four times
  faster than a bus quarter, and that nobody stretches the serial clock.
*/
`timescale 1ns/1ps
module tws_master #(
  parameter int QUARTER_CYC = tws_pkg::TWS_QUARTER_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  tws_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_two,
  input wire logic [6:0] cmd_id7,
  input wire tws_pkg::tws_addr_t cmd_reg,
  input wire tws_pkg::tws_word_t cmd_wdata,
  output logic rsp_valid,
  output tws_pkg::tws_word_t rsp_rdata,
  output logic rsp_nack
);
  import tws_pkg::*;

  // Slower quarters are fine; faster ones outrun the slave's sampler
  if (QUARTER_CYC < TWS_QUARTER_CYC || QUARTER_CYC > 65535) begin : g_chk
    $error("QUARTER_CYC out of range");
  end

  typedef struct packed {
    logic sy1;
    logic sy2;
    logic [15:0] div;
    logic [1:0] qc;
    tws_host_st_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [2:0] step;
    logic rd;
    logic two;
    logic [6:0] id7;
    tws_addr_t rg;
    tws_word_t wd;
    tws_word_t rdata;
    logic nack;
    logic ackb;
    logic scl_oe;
    logic sda_oe;
    logic rsp;
  } tws_host_s;

  tws_host_s q;
  tws_host_s d;
  logic tick;
  logic rx;
  logic last;

  // Byte sent at each step of a transfer
  function automatic logic [7:0] tx_byte(input logic [2:0] step, input tws_host_s s);
    case (step)
      3'h0: tx_byte = {s.id7, 1'b0};
      3'h1: tx_byte = s.rg;
      3'h2: tx_byte = s.wd[15:8];
      3'h3: tx_byte = s.wd[7:0];
      3'h4: tx_byte = {s.id7, 1'b1};
      default: tx_byte = 8'hff;
    endcase
  endfunction : tx_byte

  assign tick = (q.div == 16'(QUARTER_CYC - 1));
  assign rx = (q.step >= 3'h5);
  assign last = (q.step == 3'h6) || (q.step == 3'h5 && !q.two);

  // Quarter-bit sequencer
  always_comb begin
    d = q;
    d.rsp = 1'b0;
    d.sy1 = bus.sda;
    d.sy2 = q.sy1;
    d.div = (tick || q.st == TWS_H_IDLE) ? 16'h0000 : q.div + 16'h0001;
    if (q.st == TWS_H_IDLE) begin
      if (cmd_valid) begin
        d.st = TWS_H_START;
        d.qc = 2'h0;
        d.step = 3'h0;
        d.rd = cmd_read;
        d.two = cmd_two;
        d.id7 = cmd_id7;
        d.rg = cmd_reg;
        d.wd = cmd_wdata;
        d.rdata = 16'h0000;
        d.nack = 1'b0;
      end
    end else if (tick) begin
      d.qc = q.qc + 2'h1;
      unique case (q.st)
        TWS_H_START: begin
          // Same shape serves first start and repeated start
          if (q.qc == 2'h0) begin
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
          end else if (q.qc == 2'h2) begin
            d.sda_oe = 1'b1;
          end else if (q.qc == 2'h3) begin
            d.scl_oe = 1'b1;
            d.st = TWS_H_BYTE;
            d.cnt = 4'h0;
            d.sh = tx_byte(q.step, q);
          end
        end
        TWS_H_BYTE: begin
          if (q.qc == 2'h0) begin
            // Set data only while the clock is low
            if (q.cnt < TWS_BITS_PER_BYTE) begin
              d.sda_oe = rx ? 1'b0 : ~q.sh[7];
            end else begin
              d.sda_oe = rx & ~last;
            end
          end else if (q.qc == 2'h1) begin
            d.scl_oe = 1'b0;
          end else if (q.qc == 2'h2) begin
            if (q.cnt < TWS_BITS_PER_BYTE) begin
              d.sh = {q.sh[6:0], q.sy2};
            end else begin
              d.ackb = q.sy2;
            end
          end else begin
            d.scl_oe = 1'b1;
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == TWS_BITS_PER_BYTE) begin
              d.cnt = 4'h0;
              if (q.step == 3'h5) begin
                d.rdata[15:8] = q.sh;
              end
              if (q.step == 3'h6) begin
                d.rdata[7:0] = q.sh;
              end
              if (!rx && q.ackb) begin
                d.nack = 1'b1;
                d.st = TWS_H_STOP;
              end else if (q.step == 3'h1 && q.rd) begin
                d.step = 3'h4;
                d.st = TWS_H_START;
              end else if (q.step == 3'h3 || q.step == 3'h6 || (q.step[1] && !q.two) || (q.step == 3'h5 && !q.two)) begin
                d.st = TWS_H_STOP;
              end else begin
                d.step = q.step + 3'h1;
                d.sh = tx_byte(q.step + 3'h1, q);
              end
            end
          end
        end
        TWS_H_STOP: begin
          if (q.qc == 2'h0) begin
            d.sda_oe = 1'b1;
          end else if (q.qc == 2'h1) begin
            d.scl_oe = 1'b0;
          end else if (q.qc == 2'h2) begin
            d.sda_oe = 1'b0;
          end else begin
            d.st = TWS_H_IDLE;
            d.rsp = 1'b1;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cmd_ready = (q.st == TWS_H_IDLE);
  assign bus.scl_o_host = 1'b0;
  assign bus.scl_oe_host = q.scl_oe;
  assign bus.sda_o_host = 1'b0;
  assign bus.sda_oe_host = q.sda_oe;
  assign rsp_valid = q.rsp;
  assign rsp_rdata = q.rdata;
  assign rsp_nack = q.nack;
endmodule : tws_master

// ==== bench/tws_checker.sv ====
/*
  Protocol checker for the two-wire bus between master and slave.
  Assumes it sees the resolved wires and both ends' enables, and that the
  master's quarter length is handed in as QUARTER_CYC.
*/
`timescale 1ns/1ps
module tws_checker #(
  parameter int QUARTER_CYC = 32
) (
  input wire logic clk_sys,
  input wire logic clk_link,
  input wire logic resetn,
  input wire logic scl_o_host,
  input wire logic scl_oe_host,
  input wire logic sda_o_host,
  input wire logic sda_oe_host,
  input wire logic sda_o_dev,
  input wire logic sda_oe_dev,
  input wire logic scl,
  input wire logic sda
);
  typedef struct packed {
    logic scl;
    logic sda;
    logic first;
    logic rd;
    logic ended;
    logic [3:0] slot;
    logic [7:0] lo;
  } tws_chk_s;
  tws_chk_s h_q;

  // Frame tracker: slot is the bit under the present high phase, 8 being the acknowledge
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      h_q <= '0;
    end else begin
      h_q.scl <= scl;
      h_q.sda <= sda;
      h_q.lo <= scl ? 8'h00 : h_q.lo + 8'h01;
      if (scl && h_q.scl && h_q.sda && !sda) begin
        h_q.slot <= 4'hf;
        h_q.first <= 1'b1;
        h_q.rd <= 1'b0;
        h_q.ended <= 1'b0;
      end else if (h_q.scl && !scl) begin
        // Sample at the fall: data is still steady there
        h_q.slot <= (h_q.slot == 4'h8) ? 4'h0 : h_q.slot + 4'h1;
        if (h_q.slot == 4'h8) h_q.first <= 1'b0;
        if (h_q.first && h_q.slot == 4'h7) h_q.rd <= sda;
        if (h_q.slot == 4'h8 && sda) h_q.ended <= 1'b1;
      end
    end
  end

  a_one_driver_high: assert property (@(posedge clk_sys) disable iff (!resetn)
    scl |-> !(sda_oe_host && sda_oe_dev)) else $error("both ends drive data in a high clock phase");
  a_write_dev_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    scl && !h_q.rd && h_q.slot < 4'h8 |-> !sda_oe_dev) else $error("slave drives outside its ack slot");
  a_read_host_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    scl && h_q.rd && !h_q.first && !h_q.ended && h_q.slot < 4'h8 |-> !sda_oe_host)
    else $error("master drives during read data");
  a_nack_dev_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    h_q.ended |-> !sda_oe_dev) else $error("slave drives after a no-acknowledge");
  a_stop_bus_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
    scl && $past(scl) && $rose(sda) |-> (scl && sda) [*8]) else $error("bus not idle after stop");
  a_start_by_host: assert property (@(posedge clk_sys) disable iff (!resetn)
    scl && $past(scl) && $fell(sda) |-> sda_oe_host && !sda_oe_dev) else $error("start not made by master");
  a_low_phase_len: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(scl) |-> h_q.lo == 8'(2 * QUARTER_CYC) || h_q.lo == 8'(QUARTER_CYC))
    else $error("serial clock low phase of wrong length");
  a_dev_steady_high: assert property (@(posedge clk_link) disable iff (!resetn)
    scl && $past(scl) |-> $stable(sda_oe_dev)) else $error("slave changes data while clock high");
  a_dev_answer_late: assert property (@(posedge clk_link) disable iff (!resetn)
    $changed(sda_oe_dev) |-> !scl && $past(scl, 7)) else $error("slave data change not just after a fall");
endmodule : tws_checker

// ==== bench/two_wire_register_slave_tb.sv ====
/*
  Self-checking bench: master and slave joined by the two-wire bus.
  Assumes the package, interface and both ends are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e); end end
module two_wire_register_slave_tb;
  import tws_pkg::*;
  localparam int QC = 32;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] sel = 2'h0;
  tws_addr_t core_rd_addr = 8'h00;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_two = 1'b0;
  logic [6:0] cmd_id7 = 7'h00;
  tws_addr_t cmd_reg = 8'h00;
  tws_word_t cmd_wdata = 16'h0000;
  tws_word_t core_rd_data, reg_wr_data, rsp_rdata, wdat, d;
  tws_addr_t reg_wr_addr, wa, r;
  logic reg_wr_stb, cmd_ready, rsp_valid, rsp_nack;
  logic [31:0] seed = 32'h000120a8;
  int failures = 0;
  int check_count = 0;
  int wr_n = 0;
  int n0;

  initial forever #5 clk_sys = ~clk_sys;
  // Link clock offset so its edges never line up with the system clock
  initial begin
    #13;
    forever #40 clk_link = ~clk_link;
  end

  tws_if tws_bus();
  tws_master #(.QUARTER_CYC(QC)) tws_master_i (.clk_sys(clk_sys), .resetn(resetn), .bus(tws_bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_two(cmd_two), .cmd_id7(cmd_id7),
    .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
  tws_slave tws_slave_i (.clk_link(clk_link), .resetn(resetn), .bus(tws_bus), .id_select_pin_low(sel[0]),
    .id_select_pin_high(sel[1]), .core_rd_addr(core_rd_addr), .core_rd_data(core_rd_data),
    .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
  tws_checker #(.QUARTER_CYC(QC)) tws_checker_i (.clk_sys(clk_sys), .clk_link(clk_link), .resetn(resetn),
    .scl_o_host(tws_bus.scl_o_host), .scl_oe_host(tws_bus.scl_oe_host), .sda_o_host(tws_bus.sda_o_host),
    .sda_oe_host(tws_bus.sda_oe_host), .sda_o_dev(tws_bus.sda_o_dev), .sda_oe_dev(tws_bus.sda_oe_dev),
    .scl(tws_bus.scl), .sda(tws_bus.sda));

  // Log each committed register write, counted so a missing or extra one shows
  always @(posedge clk_link) begin
    if (reg_wr_stb === 1'b1) begin
      wr_n++;
      wa = reg_wr_addr;
      wdat = reg_wr_data;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Seven-bit identifier from the strap table of write identifiers
  function automatic logic [6:0] exp_id(input logic [1:0] s);
    logic [7:0] b;
    b = 8'(32'h9098b0b8 >> (8 * (3 - int'(s))));
    return b[7:1];
  endfunction : exp_id

  // One command on the master port, then a bounded wait for its response
  task automatic xfer(input logic rd, input logic two, input logic [6:0] id, input tws_addr_t ra, input tws_word_t wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_two = two;
    cmd_id7 = id;
    cmd_reg = ra;
    cmd_wdata = wd;
    @(posedge clk_sys);
    while (cmd_ready !== 1'b1) @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK(rsp_valid, 1'b1, "no response")
  endtask : xfer

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (5) @(posedge clk_link);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge clk_link);
    #1;
    // Each strap pair: own identifier writes and reads back, a neighbour's is ignored
    for (int s = 0; s < 4; s++) begin
      seed = xs(seed);
      r = (seed[7:0] == TWS_BYTE_WISE_LOW_HALF) ? 8'h09 : seed[7:0];
      d = seed[31:16];
      sel = 2'(s);
      n0 = wr_n;
      xfer(1'b0, 1'b1, exp_id(sel), r, d);
      `CHK(rsp_nack, 1'b0, "write refused")
      `CHK(wa, r, "write address")
      `CHK(wdat, d, "write data")
      `CHK(tws_slave_i.q.ptr, r + 8'h01, "pointer after word")
      xfer(1'b0, 1'b1, exp_id(sel ^ 2'h1), ~r, ~d);
      `CHK(rsp_nack, 1'b1, "foreign id answered")
      `CHK(wr_n, n0 + 1, "write count")
      xfer(1'b1, 1'b1, exp_id(sel), r, 16'h0000);
      `CHK(rsp_rdata, d, "read word")
      `CHK(tws_slave_i.q.ptr, r + 8'h01, "pointer after read")
      core_rd_addr = r;
      repeat (2) @(posedge clk_link);
      #1;
      `CHK(core_rd_data, d, "stored word")
      $display("strap test %0d done", s);
    end
    // Byte-wise access: upper byte at the register, lower byte through 0xf0
    seed = xs(seed);
    r = (seed[7:0] == TWS_BYTE_WISE_LOW_HALF) ? 8'h21 : seed[7:0];
    d = seed[31:16];
    n0 = wr_n;
    xfer(1'b0, 1'b0, exp_id(sel), r, {d[15:8], 8'h00});
    `CHK(wr_n, n0, "half word committed")
    xfer(1'b0, 1'b0, exp_id(sel), TWS_BYTE_WISE_LOW_HALF, {d[7:0], 8'h00});
    `CHK(wa, r, "byte-wise address")
    `CHK(wdat, d, "byte-wise word")
    xfer(1'b1, 1'b0, exp_id(sel), r, 16'h0000);
    `CHK(rsp_rdata, {d[15:8], 8'h00}, "upper byte read")
    xfer(1'b1, 1'b0, exp_id(sel), TWS_BYTE_WISE_LOW_HALF, 16'h0000);
    `CHK(rsp_rdata, {d[7:0], 8'h00}, "lower byte read")
    $display("byte-wise test done");
    summarize();
  end

  // Expected run is near 67000 cycles; this cuts a hang short
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    summarize();
  end
endmodule : two_wire_register_slave_tb
